// [logic/pipelined_burst_sram_port.sv]
// burst sram access pipeline with pending write fifo and storage array
`timescale 1ns/1ps
`include "sram_port_defines.svh"

// small valid/ready queue for pending write beats
// depth must stay a power of two so the pointers wrap by themselves
// the slots are plain flops; a reset clears only pointers and count
module write_addr_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_resetn,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);
  // count is one bit wider than the pointers so full and empty differ
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0]   count;
  } fifo_state_t;

  fifo_state_t    f_q;
  fifo_state_t    f_d;
  logic [W-1:0]   slots [DEPTH];
  logic           push;
  logic           pop;

  // honest flags straight from the occupancy count
  assign o_in_ready  = (f_q.count != (PW+1)'(DEPTH));
  assign o_out_valid = (f_q.count != '0);
  assign o_out_data  = slots[f_q.rd_ptr];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  // pointers wrap because depth is a power of two
  always_comb begin
    f_d = f_q;
    if (push) begin
      f_d.wr_ptr = f_q.wr_ptr + PW'(1);
    end
    if (pop) begin
      f_d.rd_ptr = f_q.rd_ptr + PW'(1);
    end
    // simultaneous push and pop leave the count unchanged
    f_d.count = f_q.count + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      f_q <= '0;
    end else begin
      f_q <= f_d;
    end
  end

  // storage is not reset; only occupied slots are ever read
  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      slots[f_q.wr_ptr] <= i_in_data;
    end
  end

  // the port only pushes while ready and pops while valid; a slip here
  // would silently lose or replay a pending write
  a_fifo_no_overflow: assert property (@(posedge i_ref_clk) disable iff (!i_resetn) // [RULE16]
      i_in_valid |-> o_in_ready)
    else $error("pending write fifo overflowed");
  a_fifo_no_underflow: assert property (@(posedge i_ref_clk) disable iff (!i_resetn) // [RULE16]
      i_out_ready |-> o_out_valid)
    else $error("pending write fifo read while empty");
endmodule // write_addr_fifo

// command pipeline of the port:
//   edge e0 decodes a load, a step or a deselect into stage one
//   edge e1 moves stage one to stage two and loads the read register
//   edge e2 commits a pending write from the data lanes into the array
// a held clock qualifier freezes every stage, so e1 and e2 count only
// qualified edges; the fifo carries address and byte mask of each write
// beat to its data edge, since later commands overwrite both stages
module pipelined_burst_sram_port
  import sram_port_pkg::*;
(
  input  wire logic               i_ref_clk,
  input  wire logic               i_resetn,
  input  wire logic               i_clk_qualify_n,
  input  wire logic               i_chip_select_1_n,
  input  wire logic               i_chip_select_2,
  input  wire logic               i_chip_select_3_n,
  input  wire logic               i_step_or_load_n,
  input  wire logic               i_rw_select,
  input  wire logic [`LANES-1:0]  i_byte_lane_select_n,
  input  wire logic               i_burst_order_select,
  input  wire logic               i_output_drive_enable_n,
  input  wire logic [`ADDR_W-1:0] i_addr,
  input  wire logic [`DATA_W-1:0] i_dq,
  input  wire logic [`LANES-1:0]  i_parity_lanes,
  output logic [`DATA_W-1:0]      o_dq,
  output logic [`LANES-1:0]       o_parity_lanes,
  output logic                    o_dq_oe_n,
  output logic                    o_parity_lanes_oe_n
);
  localparam int FW = `ADDR_W + `LANES;

  // pipeline state and the storage array
  port_state_t          s_q;
  port_state_t          s_d;
  logic [`WORD_W-1:0]   mem [`MEM_WORDS];
  // decode and fifo handshake
  logic                 adv;
  logic                 sel_all;
  logic                 fifo_ready;
  logic                 fifo_valid;
  logic                 push;
  logic                 pop;
  logic [FW-1:0]        push_data;
  logic [FW-1:0]        head;
  logic [`ADDR_W-1:0]   head_addr;
  logic [`LANES-1:0]    head_mask_n;
  // lane words on their way in and out
  logic [`WORD_W-1:0]   wr_word;
  logic [`WORD_W-1:0]   rd_raw;
  logic [`WORD_W-1:0]   commit_word;
  op_t                  cur_op;
  logic [`ADDR_W-1:0]   cur_addr;
  logic [`CNT_W-1:0]    next_cnt;

  // replace only the lanes whose select is low, parity bit included
  function automatic logic [`WORD_W-1:0] merge_lanes(
    input logic [`WORD_W-1:0] old_w,
    input logic [`WORD_W-1:0] new_w,
    input logic [`LANES-1:0]  sel_n
  );
    logic [`WORD_W-1:0] r;
    // unselected lanes keep the word already in the array
    r = old_w;
    for (int i = 0; i < `LANES; i++) begin
      if (!sel_n[i]) begin
        r[i*`LANE_W +: `LANE_W] = new_w[i*`LANE_W +: `LANE_W]; // [RULE17]
        r[`PAR_LSB+i]           = new_w[`PAR_LSB+i];           // [RULE22]
      end
    end
    return r;
  endfunction

  // a full fifo stalls the pipe like a held clock qualifier
  // waiting is preferred to dropping a write; legal traffic never fills it
  assign adv         = ~i_clk_qualify_n & fifo_ready;        // [RULE2]
  assign sel_all     = ~i_chip_select_1_n & i_chip_select_2 & ~i_chip_select_3_n;
  assign head_addr   = head[FW-1:`LANES];
  assign head_mask_n = head[`LANES-1:0];
  assign wr_word     = {i_parity_lanes, i_dq};
  assign rd_raw      = mem[s_q.addr1];
  assign commit_word = merge_lanes(mem[head_addr], wr_word, head_mask_n);

  // pending writes wait here from command edge to data edge
  // at most two are in flight, so depth four leaves headroom
  write_addr_fifo #(
    .W     (FW),
    .DEPTH (`FIFO_DEPTH)
  ) u_wr_fifo (
    .i_ref_clk   (i_ref_clk),
    .i_resetn    (i_resetn),
    .i_in_valid  (push),
    .o_in_ready  (fifo_ready),
    .i_in_data   (push_data),
    .o_out_valid (fifo_valid),
    .i_out_ready (pop),
    .o_out_data  (head)
  );

  // command decode, burst sequencing and the two pipeline stages
  always_comb begin
    s_d       = s_q;
    cur_op    = OP_IDLE;
    cur_addr  = s_q.addr1;
    next_cnt  = s_q.cnt + `CNT_STEP;
    push      = 1'b0;
    pop       = 1'b0;
    push_data = '0;
    if (adv) begin
      if (i_step_or_load_n) begin
        // selects and rw_select are ignored while stepping
        if (s_q.burst_op != OP_IDLE) begin                       // [RULE12]
          s_d.cnt  = next_cnt;                                   // [RULE11]
          cur_op   = s_q.burst_op;                               // [RULE13]
          // base stays put during a burst; only its low bits are replaced
          cur_addr = s_q.base;
          if (i_burst_order_select) begin                        // [RULE10]
            cur_addr[`CNT_W-1:0] = s_q.base[`CNT_W-1:0] ^ next_cnt; // [RULE21]
          end else begin
            cur_addr[`CNT_W-1:0] = s_q.base[`CNT_W-1:0] + next_cnt; // [RULE21]
          end
        end
      end else if (sel_all) begin
        s_d.base     = i_addr;                                   // [RULE1]
        s_d.cnt      = `CNT_RST;                                 // [RULE9]
        s_d.burst_op = i_rw_select ? OP_READ : OP_WRITE;         // [RULE4] [RULE14]
        cur_op       = s_d.burst_op;
        cur_addr     = i_addr;
      end else begin
        // deselect ends the burst; pending data still completes
        // a deselect carries no address, stage one simply goes idle
        s_d.burst_op = OP_IDLE;                                  // [RULE7]
      end
      // each write beat queues its own address and mask; the mask is not
      // sampled again at the data edge, so the controller repeats it per beat
      if (cur_op == OP_WRITE) begin
        push      = 1'b1;
        push_data = {cur_addr, i_byte_lane_select_n};            // [RULE19]
      end
      // back-to-back commands just shift through; no idle slot is needed
      s_d.op1   = cur_op;                                        // [RULE6]
      s_d.addr1 = cur_addr;
      s_d.op2   = s_q.op1;
      // second qualified edge after a write command commits it
      if (s_q.op2 == OP_WRITE) begin
        pop = fifo_valid;                                        // [RULE16]
      end
      // output register loads one edge after the read address edge
      if (s_q.op1 == OP_READ) begin
        s_d.rdata = rd_raw;                                      // [RULE5]
        // without the bypass the read would return the word before the merge
        if (pop && (head_addr == s_q.addr1)) begin
          s_d.rdata = commit_word;  // bypass the same-edge write
        end
      end
      // writes and deselects float the lanes after their next edge
      // the enable pin stays outside this register so it acts at once
      s_d.drive = (s_q.op1 == OP_READ);                          // [RULE15] [RULE24]
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      // control stages go idle; read data returns to zero but never reaches the lanes,
      // since the edge that first sets the drive register also loads the read word
      s_q          <= '0;                                        // [RULE23]
      s_q.op1      <= OP_IDLE;
      s_q.op2      <= OP_IDLE;
      s_q.burst_op <= OP_IDLE;
    end else begin
      s_q <= s_d;                                                // [RULE1]
    end
  end

  // array write; selected lanes only, others keep old contents
  // the array has no reset; a read before any write returns unknown
  always_ff @(posedge i_ref_clk) begin
    if (pop) begin
      mem[head_addr] <= commit_word;                             // [RULE17]
    end
  end

  // data comes from the output register; enable is gated asynchronously
  // both lane groups share one enable; they never turn round separately
  // lanes float whenever the drive register is clear or the enable pin is high
  assign o_dq                = s_q.rdata[`DATA_W-1:0];           // [RULE3]
  assign o_parity_lanes      = s_q.rdata[`WORD_W-1:`PAR_LSB];
  assign o_dq_oe_n           = ~(s_q.drive & ~i_output_drive_enable_n); // [RULE8]
  assign o_parity_lanes_oe_n = o_dq_oe_n;

  // checks run on the port clock and stay quiet while reset is held, except a_reset_float and a_reset_idle
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  // command decodes used only by the checks below
  logic cmd_rd;
  logic cmd_wr;
  logic cmd_desel;
  logic step_act;
  assign cmd_rd    = adv & ~i_step_or_load_n & sel_all & i_rw_select;
  assign cmd_wr    = adv & ~i_step_or_load_n & sel_all & ~i_rw_select;
  assign cmd_desel = adv & ~i_step_or_load_n & ~sel_all;
  assign step_act  = adv & i_step_or_load_n & (s_q.burst_op != OP_IDLE);

  a_stall_holds: assert property (i_clk_qualify_n |=> $stable(s_q)) // [RULE2]
    else $error("state moved during a stalled clock");
  a_read_drive: assert property (cmd_rd ##1 adv |=> s_q.drive && s_q.op2 == OP_READ) // [RULE5]
    else $error("read data not driven after its second edge");
  a_write_float: assert property (cmd_wr ##1 adv |=> !s_q.drive) // [RULE15]
    else $error("lanes driven during write data cycle");
  a_desel_float: assert property (cmd_desel ##1 adv |=> o_dq_oe_n) // [RULE7]
    else $error("lanes driven after deselect");
  a_oe_gate: assert property (!i_output_drive_enable_n && s_q.drive |-> !o_dq_oe_n) // [RULE8]
    else $error("output enable ignored");
  a_write_commit: assert property (cmd_wr ##1 adv ##1 adv |-> pop) // [RULE16]
    else $error("write not committed on second edge");
  a_count_wrap: assert property (step_act |=> s_q.cnt == $past(s_q.cnt) + `CNT_STEP) // [RULE11]
    else $error("burst counter did not step");
  a_dir_kept: assert property (step_act |=> s_q.op1 == $past(s_q.burst_op)) // [RULE13]
    else $error("burst direction changed");
  a_order_xor: assert property (step_act && i_burst_order_select
      |=> s_q.addr1[1:0] == (s_q.base[1:0] ^ s_q.cnt)) // [RULE21]
    else $error("interleaved address wrong");
  a_order_lin: assert property (step_act && !i_burst_order_select
      |=> s_q.addr1[1:0] == s_q.base[1:0] + s_q.cnt) // [RULE21]
    else $error("linear address wrong");
  a_reset_float: assert property (@(posedge i_ref_clk) disable iff (1'b0)
      !i_resetn |=> o_dq_oe_n) // [RULE23]
    else $error("lanes driven after reset");

  // load, step and deselect bookkeeping
  a_exit_float: assert property (adv && s_q.op1 == OP_IDLE |=> !s_q.drive) // [RULE24]
    else $error("lanes driven in first clock after deselect");
  a_load_base: assert property ((cmd_rd || cmd_wr) // [RULE9]
      |=> s_q.base == $past(i_addr) && s_q.cnt == `CNT_RST)
    else $error("burst base not loaded");
  a_step_keeps_dir: assert property (step_act |=> s_q.burst_op == $past(s_q.burst_op)) // [RULE12]
    else $error("step changed the open burst");
  a_idle_step: assert property (adv && i_step_or_load_n && s_q.burst_op == OP_IDLE // [RULE12]
      |=> s_q.op1 == OP_IDLE)
    else $error("step without an open burst started an access");
  a_desel_ends: assert property (cmd_desel |=> s_q.burst_op == OP_IDLE) // [RULE7]
    else $error("deselect left the burst open");
  a_write_queued: assert property (cmd_wr |-> push) // [RULE14]
    else $error("write command not queued");
  a_read_unqueued: assert property (cmd_rd |-> !push) // [RULE4]
    else $error("read command queued as a write");

  // drive register follows stage one
  a_read_drives: assert property (adv && s_q.op1 == OP_READ |=> s_q.drive) // [RULE5]
    else $error("read stage did not set the drive register");
  a_write_floats: assert property (adv && s_q.op1 == OP_WRITE |=> !s_q.drive) // [RULE15]
    else $error("write stage left the drive register set");

  // nothing may move or commit while the pipe is held
  a_freeze_commit: assert property (i_clk_qualify_n |-> !pop) // [RULE2]
    else $error("write committed during a stalled clock");
  a_data_held: assert property (!adv |=> $stable(o_dq) && $stable(o_parity_lanes)) // [RULE3]
    else $error("read data moved without a qualified edge");

  // reset returns every stage to idle
  a_reset_idle: assert property (@(posedge i_ref_clk) disable iff (1'b0) // [RULE23]
      !i_resetn |=> s_q.op1 == OP_IDLE && s_q.burst_op == OP_IDLE)
    else $error("stages not idle after reset");

  // main scenarios the bench should reach
  c_read: cover property (cmd_rd ##1 adv ##1 !o_dq_oe_n);
  c_write: cover property (cmd_wr ##1 adv ##1 adv ##1 1'b1);
  c_burst4: cover property (cmd_rd ##1 step_act ##1 step_act ##1 step_act);
  c_rw_turn: cover property (cmd_wr ##1 cmd_rd ##1 cmd_wr);
  c_stall: cover property (cmd_rd ##1 i_clk_qualify_n [*2] ##1 adv);
endmodule // pipelined_burst_sram_port

// [logic/sram_port_defines.svh]
// constants for the pipelined burst sram access port
// Functional notes
// [RULE1] all synchronous inputs are captured on the rising clock edge only
// [RULE2] clk_qualify_n high freezes every register, extending the previous cycle
// [RULE3] read data leaves through output registers clocked on the rising edge
// [RULE4] read starts: qualified edge, all selects active, rw_select high, load
// [RULE5] read word passes the output register one edge after the address edge
// [RULE6] a new command may follow in the second read cycle, no idle cycles
// [RULE7] deselect is pipelined; outputs float after the following edge
// [RULE8] after the first read clock drive follows output_drive_enable_n and control
// [RULE9] internal burst counter gives up to four beats from one address
// [RULE10] burst_order_select low gives linear order, high interleaved
// [RULE11] counter uses the two low address bits and wraps in the group
// [RULE12] step_or_load_n high advances the counter, ignoring selects and rw_select
// [RULE13] direction captured at burst load holds for every beat
// [RULE14] write starts: qualified edge, all selects active, rw_select low
// [RULE15] edge after a write command floats the lanes; next command may load
// [RULE16] write data is captured on the second qualified edge after the command
// [RULE17] only selected byte lanes are updated
// [RULE18] controller avoids driving the bus while device outputs are active
// [RULE19] controller drives the correct byte mask in every burst beat
// [RULE20] controller loads a fresh address after a deselect
// [RULE21] linear adds beat count modulo four, interleaved xors the beat count
// [RULE22] each byte select gates its data byte and its parity bit
// [RULE23] after reset the port is deselected with lanes floating
// [RULE24] lanes float during the first clock after leaving deselect
`ifndef SRAM_PORT_DEFINES_SVH
`define SRAM_PORT_DEFINES_SVH
`define ADDR_W     19
`define LANES      4
`define LANE_W     8
`define DATA_W     32
`define WORD_W     36
`define PAR_LSB    32
`define CNT_W      2
`define CNT_RST    2'h0
`define CNT_STEP   2'h1
`define FIFO_DEPTH 4
`define MEM_WORDS  (1 << `ADDR_W)
`endif

// [logic/sram_port_pkg.sv]
// types shared by the burst sram access port
package sram_port_pkg;
  `include "sram_port_defines.svh"

  // gray along idle -> read -> write
  typedef enum logic [1:0] {
    OP_IDLE  = 2'b00,
    OP_READ  = 2'b01,
    OP_WRITE = 2'b11
  } op_t;

  typedef struct packed {
    op_t                 op1;
    logic [`ADDR_W-1:0]  addr1;
    op_t                 op2;
    logic [`ADDR_W-1:0]  base;
    logic [`CNT_W-1:0]   cnt;
    op_t                 burst_op;
    logic [`WORD_W-1:0]  rdata;
    logic                drive;
  } port_state_t;
endpackage

// [verification/ctrl_bus_model.sv]
// memory controller side of the shared data and parity lanes
`timescale 1ns/1ps

module ctrl_bus_model (
  input  wire logic        i_ref_clk,
  input  wire logic        i_drive,
  input  wire logic [35:0] i_wdata,
  input  wire logic [35:0] i_dev_word,
  input  wire logic        i_dev_oe_n,
  output logic [35:0]      o_bus
);
  logic [35:0] last_q;

  // device drive wins; the controller yields while the device drives
  always_comb begin
    if (!i_dev_oe_n) begin
      o_bus = i_dev_word;
    end else if (i_drive) begin
      o_bus = i_wdata; // write data for the second edge after the command
    end else begin
      o_bus = ~last_q; // released lanes never hold the old value
    end
  end

  // remember the level so a released bus keeps toggling
  always_ff @(posedge i_ref_clk) begin
    last_q <= o_bus;
  end
endmodule // ctrl_bus_model

// [verification/pipelined_burst_sram_port_tb.sv]
// self-checking bench for the burst sram access port
`timescale 1ns/1ps
`include "sram_port_defines.svh"

module pipelined_burst_sram_port_tb;
  import sram_port_pkg::*;
  typedef struct packed {
    logic l; logic r; logic s; logic [7:0] a; logic [3:0] m; logic d; logic [35:0] w; logic eo; logic [35:0] ew;
  } row_t;
  logic               ref_clk, resetn, cen_n, cs1_n, cs2, cs3_n, ld_n, rw, order, oe_in_n, drv;
  logic [`ADDR_W-1:0] addr;
  logic [3:0]         mask, par;
  logic [35:0]        wd, bus;
  logic [`DATA_W-1:0] dq;
  logic               dq_oe_n, par_oe_n;
  int                 errors, checked;
  row_t               rows [10];

  pipelined_burst_sram_port dut (.i_ref_clk(ref_clk), .i_resetn(resetn), .i_clk_qualify_n(cen_n),
    .i_chip_select_1_n(cs1_n), .i_chip_select_2(cs2), .i_chip_select_3_n(cs3_n), .i_step_or_load_n(ld_n),
    .i_rw_select(rw), .i_byte_lane_select_n(mask), .i_burst_order_select(order),
    .i_output_drive_enable_n(oe_in_n), .i_addr(addr), .i_dq(bus[31:0]), .i_parity_lanes(bus[35:32]),
    .o_dq(dq), .o_parity_lanes(par), .o_dq_oe_n(dq_oe_n), .o_parity_lanes_oe_n(par_oe_n));
  ctrl_bus_model partner (.i_ref_clk(ref_clk), .i_drive(drv), .i_wdata(wd), .i_dev_word({par, dq}),
    .i_dev_oe_n(dq_oe_n), .o_bus(bus));

  // 40 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // one qualified or frozen cycle, inputs applied at the falling edge
  task automatic cyc(input logic c, l, r, s, input logic [7:0] a, input logic [3:0] m, input logic d,
                     input logic [35:0] w);
    cen_n = c;
    ld_n = l;
    rw = r;
    cs1_n = ~s;
    cs2 = s;
    cs3_n = ~s;
    addr = {11'h0, a};
    mask = m;
    drv = d;
    wd = w;
    @(negedge ref_clk);
  endtask

  task automatic chk_bit(input string name, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic chk_word(input logic [35:0] exp);
    checked++;
    if ({par, dq} !== exp) begin
      errors++;
      $display("wrong value read word expected %h seen %h", exp, {par, dq});
    end
  endtask

  // drive state always; the word only when the port should drive
  task automatic chk_out(input logic eo, input logic [35:0] ew);
    chk_bit("dq oe", eo, dq_oe_n);
    chk_bit("parity oe", eo, par_oe_n);
    if (!eo) chk_word(ew);
  endtask

  task automatic print_verdict;
    if (errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // a hang is cut short well past the expected run of about twenty-five cycles
  initial begin
    #(400 * 25);
    errors++;
    print_verdict();
  end

  initial begin
    // write burst from 12 wrapping to 12, reads back with a lane merge, then deselect
    rows[0] = '{0, 0, 1, 8'h12, 4'h0, 0, 36'h0, 1, 36'h0};
    rows[1] = '{1, 0, 0, 8'hFF, 4'h0, 0, 36'h0, 1, 36'h0};
    rows[2] = '{1, 1, 0, 8'hFF, 4'h0, 1, 36'h111111111, 1, 36'h0};
    rows[3] = '{1, 1, 0, 8'hFF, 4'h0, 1, 36'h222222222, 1, 36'h0};
    rows[4] = '{1, 0, 1, 8'hFF, 4'hE, 1, 36'h333333333, 1, 36'h0};
    rows[5] = '{0, 1, 1, 8'h12, 4'hF, 1, 36'h444444444, 1, 36'h0};
    rows[6] = '{1, 0, 1, 8'h00, 4'hF, 1, 36'hFFFFFFFFF, 0, 36'h1111111FF};
    rows[7] = '{1, 0, 1, 8'h00, 4'hF, 0, 36'h0, 0, 36'h222222222};
    rows[8] = '{0, 0, 0, 8'h00, 4'hF, 0, 36'h0, 0, 36'h333333333};
    rows[9] = '{0, 0, 0, 8'h00, 4'hF, 0, 36'h0, 1, 36'h0};
    resetn = 1'b0;
    order = 1'b0;
    oe_in_n = 1'b0;
    cyc(0, 0, 0, 0, 8'h00, 4'hF, 0, 36'h0);
    repeat (2) @(negedge ref_clk);
    resetn = 1'b1;
    chk_out(1, 36'h0);
    // linear write burst, ignored selects and direction on steps, byte lanes
    foreach (rows[i]) begin
      cyc(0, rows[i].l, rows[i].r, rows[i].s, rows[i].a, rows[i].m, rows[i].d, rows[i].w);
      chk_out(rows[i].eo, rows[i].ew);
    end
    // load out of deselect, then freeze before the data edge
    cyc(0, 0, 1, 1, 8'h13, 4'hF, 0, 36'h0);
    chk_out(1, 36'h0);
    cyc(1, 0, 0, 0, 8'h00, 4'hF, 0, 36'h0);
    chk_out(1, 36'h0);
    cyc(0, 0, 0, 0, 8'h00, 4'hF, 0, 36'h0);
    chk_out(0, 36'h222222222);
    cyc(1, 0, 1, 1, 8'h10, 4'hF, 0, 36'h0);
    chk_out(0, 36'h222222222);
    oe_in_n = 1'b1;
    #1 chk_out(1, 36'h0);
    oe_in_n = 1'b0;
    #1 chk_out(0, 36'h222222222);
    cyc(0, 0, 0, 0, 8'h00, 4'hF, 0, 36'h0);
    chk_out(1, 36'h0);
    // interleaved read burst from 11: 11, 10, 13, 12
    order = 1'b1;
    cyc(0, 0, 1, 1, 8'h11, 4'hF, 0, 36'h0);
    chk_out(1, 36'h0);
    cyc(0, 1, 0, 0, 8'h00, 4'hF, 0, 36'h0);
    chk_out(0, 36'h444444444);
    cyc(0, 1, 0, 0, 8'h00, 4'hF, 0, 36'h0);
    chk_out(0, 36'h333333333);
    cyc(0, 1, 0, 0, 8'h00, 4'hF, 0, 36'h0);
    chk_out(0, 36'h222222222);
    cyc(0, 0, 0, 0, 8'h00, 4'hF, 0, 36'h0);
    chk_out(0, 36'h1111111FF);
    cyc(0, 1, 0, 0, 8'h00, 4'hF, 0, 36'h0);
    chk_out(1, 36'h0);
    // a step with no open burst starts nothing
    cyc(0, 1, 1, 0, 8'h00, 4'hF, 0, 36'h0);
    chk_out(1, 36'h0);
    print_verdict();
  end
endmodule // pipelined_burst_sram_port_tb
